// ---- hw/vic_regs.svh ----
// offsets, vectors and reset values of the vectored interrupt controller
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH
`define OFF_STATUS_LOW   8'h00
`define OFF_STATUS_MID   8'h04
`define OFF_STATUS_HIGH  8'h08
`define OFF_MASK_LOW     8'h0C
`define OFF_MASK_HIGH    8'h10
`define OFF_CONTROL      8'h14
`define OFF_VECTOR       8'h18
`define CTRL_GIE_BIT     0
`define CTRL_WDT_EN_BIT  1
`define CTRL_ACTIVE_BIT  2
`define CTRL_CHANGE_BIT  3
`define STAT_CHANGE_BIT  5
`define VEC_RESET        16'h0000
`define VEC_WATCHDOG     16'h0003
`define VEC_EXT0         16'h0006
`define VEC_TICK         16'h0009
`define VEC_EXT1         16'h000F
`define VEC_TIMEBASE     16'h0012
`define VEC_SER_TX       16'h0015
`define VEC_SER_RX       16'h0018
`define VEC_SER_ERR      16'h001B
`define VEC_TIMER3       16'h0021
`define VEC_SPI          16'h0024
`define VEC_TIMER4       16'h0027
`define VEC_EXT3         16'h002A
`define VEC_CONV         16'h0030
`define VEC_TIMER2       16'h0033
`define VEC_EXT5         16'h0036
`define NUM_SOURCES      15
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// ---- hw/vic_pkg.sv ----
// types of the vectored interrupt controller
package vic_pkg;
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_WAIT  = 2'b10
    } take_state_t;
endpackage

// ---- hw/prio_pick.sv ----
// fixed priority picker, lowest index wins
`timescale 1ns/1ns
`default_nettype none
module prio_pick #(
    parameter int N = 15
) (
    // request vector
    input  wire logic [N-1:0] req,
    // winner
    output logic              any,
    output logic [3:0]        idx
);
    if (N < 1 || N > 16) begin : g_bad_width
        $error("prio_pick width out of range");
    end
    // smallest number first
    always_comb begin
        any = 1'b0;
        idx = 4'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                any = 1'b1;
                idx = 4'(i);
            end
        end
    end
endmodule // prio_pick
`default_nettype wire

// ---- hw/flag_cell.sv ----
// sticky request flag, set beats clear
`timescale 1ns/1ns
`default_nettype none
module flag_cell (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // events
    input  wire logic set,
    input  wire logic clr,
    // flag
    output logic      flag
);
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule // flag_cell
`default_nettype wire

// ---- hw/vectored_interrupt_controller.sv ----
// vectored priority interrupt controller with axi4-lite registers
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "vic_regs.svh"
// Overview of operation
// R1: fifteen sources, each with its own flag and fixed vector
// R2: reset sends fetch to vector zero, top rank, no enable or flag
// R3: watchdog sets its flag, vectors 0x0003, needs only its own enable
// R4: ext0 to 0x0006, tick counter to 0x0009, need global and own enable
// R5: ext1 to 0x000F, time base to 0x0012, need global and own enable
// R6: serial tx 0x0015, rx 0x0018, error 0x001B, global and own enable
// R7: timer3 0x0021, spi 0x0024, timer4 0x0027, global and own enable
// R8: ext3 to 0x002A, conversion done to 0x0030, global and own enable
// R9: timer2 to 0x0033, ext5 to 0x0036 lowest, global and own enable
// R10: flags sit in three status registers, enables in two mask registers
// R11: enable instruction sets global enable, disable instruction clears it
// R12: taken request loads the program counter with its vector
// R13: software clears the serviced flag before returning or re-enabling
// R14: high status flags except input change set regardless of masks
// R15: return instruction pops the address and sets global enable
// R16: several pending enabled requests, smallest priority number first
// R17: taking a request pushes return address and clears global enable
module vectored_interrupt_controller
    import vic_pkg::*;
#(
    parameter int NSRC = `NUM_SOURCES
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // source events, one-cycle pulses, priority order 1..15
    input  wire logic [14:0] src_event,
    input  wire logic        input_change_event,
    // core instruction events
    input  wire logic        global_enable_instr,
    input  wire logic        global_disable_instr,
    input  wire logic        return_and_enable_instr,
    input  wire logic        fetch_ready,
    // fetch redirect
    output logic             pc_load,
    output logic [15:0]      pc_vector,
    output logic             push_return,
    output logic             global_enable,
    output logic             irq_pending
);
    if (NSRC != `NUM_SOURCES) begin : g_bad_count
        $error("source count must be fifteen");
    end

    // vector table in priority order
    // R1: fixed vectors
    localparam logic [15:0] VEC_TABLE [15] = '{
        `VEC_WATCHDOG,
        `VEC_EXT0,
        `VEC_TICK,
        `VEC_EXT1,
        `VEC_TIMEBASE,
        `VEC_SER_TX,
        `VEC_SER_RX,
        `VEC_SER_ERR,
        `VEC_TIMER3,
        `VEC_SPI,
        `VEC_TIMER4,
        `VEC_EXT3,
        `VEC_CONV,
        `VEC_TIMER2,
        `VEC_EXT5
    };

    logic [14:0]   flags;
    logic [14:0]   mask;
    logic          watchdog_enable_bit;
    logic          input_change_flag;
    logic          wdt_en_seen;
    take_state_t   state;
    take_state_t   next_state;
    logic [3:0]    taken_idx;

    // bus holding registers
    logic          aw_held;
    logic          w_held;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;

    wire           wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire           rd_fire = s_axi_arvalid && s_axi_arready;

    function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    // offsets that answer okay, shared by both channels
    function automatic logic known_offset(input logic [7:0] a);
        case (a)
            `OFF_STATUS_LOW,
            `OFF_STATUS_MID,
            `OFF_STATUS_HIGH,
            `OFF_MASK_LOW,
            `OFF_MASK_HIGH,
            `OFF_CONTROL,
            `OFF_VECTOR: known_offset = 1'b1;
            default:     known_offset = 1'b0;
        endcase
    endfunction

    wire           wr_st_low  = wr_fire && addr_hit(aw_addr, `OFF_STATUS_LOW);
    wire           wr_st_mid  = wr_fire && addr_hit(aw_addr, `OFF_STATUS_MID);
    wire           wr_st_high = wr_fire && addr_hit(aw_addr, `OFF_STATUS_HIGH);
    wire           wr_m_low   = wr_fire && addr_hit(aw_addr, `OFF_MASK_LOW);
    wire           wr_m_high  = wr_fire && addr_hit(aw_addr, `OFF_MASK_HIGH);
    wire           wr_ctrl    = wr_fire && addr_hit(aw_addr, `OFF_CONTROL);
    wire           wr_known   = wr_fire && known_offset(aw_addr);

    // flag clear: write one to clear, bytes low/mid/high hold 5 flags each
    // R13: software clear path
    wire [14:0]    clr_vec = {
        (wr_st_high && w_strb[0]) ? w_data[4:0] : 5'h00,
        (wr_st_mid  && w_strb[0]) ? w_data[4:0] : 5'h00,
        (wr_st_low  && w_strb[0]) ? w_data[4:0] : 5'h00};

    // R10: three status registers of flags
    // R14: flags set whatever the masks
    // R3: watchdog flag set by its event
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_flag
            flag_cell u_flag (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .set     (src_event[g]),
                .clr     (clr_vec[g]),
                .flag    (flags[g])
            );
        end
    endgenerate

    // input change flag only sets while the ext5 mask bit, mask[14], is on
    // R14: input change exception
    flag_cell u_change (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .set     (input_change_event && mask[14]),
        .clr     (wr_st_high && w_strb[0] && w_data[`STAT_CHANGE_BIT]),
        .flag    (input_change_flag)
    );

    // qualification
    // R3: watchdog needs only its own enable
    // R4: ext0 and tick need global and own enable
    // R5: ext1 and time base gated
    // R6: serial sources gated
    // R7: timers and spi gated
    // R8: ext3 and conversion gated
    // R9: timer2 and ext5 gated
    wire [14:0]    qualified = {flags[14:1] & mask[14:1] & {14{global_enable}},
                                flags[0] & watchdog_enable_bit};

    wire           pick_any;
    wire [3:0]     pick_idx;

    // R16: smallest number first
    prio_pick #(.N(NSRC)) u_pick (
        .req (qualified),
        .any (pick_any),
        .idx (pick_idx)
    );

    // take and redirect strobes
    wire           take     = (state == ST_IDLE) && pick_any;
    wire           load_now = (state == ST_FETCH) && fetch_ready;

    // take sequence
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:  next_state = pick_any ? ST_FETCH : ST_IDLE;
            ST_FETCH: next_state = fetch_ready ? ST_WAIT : ST_FETCH;
            ST_WAIT:  next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            state     <= ST_IDLE;
            taken_idx <= 4'h0;
        end else begin
            state <= next_state;
            if (take) begin
                taken_idx <= pick_idx;
            end
        end
    end

    // R12: load pc with vector
    // R17: push and disable
    // R2: reset vectors to zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pc_load     <= 1'b1;
            pc_vector   <= `VEC_RESET;
            push_return <= 1'b0;
        end else begin
            pc_load     <= load_now;
            push_return <= load_now;
            if (load_now) begin
                pc_vector <= VEC_TABLE[taken_idx];
            end
        end
    end

    // global enable
    // R11: enable and disable instr
    // R15: return sets enable
    // R17: taking clears enable
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            global_enable <= 1'b0;
        end else if (take) begin
            global_enable <= 1'b0;
        end else if (global_enable_instr || return_and_enable_instr) begin
            global_enable <= 1'b1;
        end else if (global_disable_instr) begin
            global_enable <= 1'b0;
        end else if (wr_ctrl && w_strb[0]) begin
            global_enable <= w_data[`CTRL_GIE_BIT];
        end
    end

    // R10: two mask registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mask                <= 15'h0000;
            watchdog_enable_bit <= 1'b0;
            wdt_en_seen         <= 1'b0;
            irq_pending         <= 1'b0;
        end else begin
            irq_pending <= pick_any;
            wdt_en_seen <= watchdog_enable_bit;
            if (wr_m_low && w_strb[0]) begin
                mask[7:1] <= w_data[7:1];
            end
            if (wr_m_high && w_strb[0]) begin
                mask[14:8] <= w_data[6:0];
            end
            if (wr_ctrl && w_strb[0]) begin
                watchdog_enable_bit <= w_data[`CTRL_WDT_EN_BIT];
            end
        end
    end

    // write channel
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read decode
    wire [31:0]    ctrl_word = {28'h0000000, input_change_flag,
                                (state != ST_IDLE), wdt_en_seen, global_enable};
    wire [31:0]    rd_word =
        (s_axi_araddr == `OFF_STATUS_LOW)  ? {27'h0, flags[4:0]} :
        (s_axi_araddr == `OFF_STATUS_MID)  ? {27'h0, flags[9:5]} :
        (s_axi_araddr == `OFF_STATUS_HIGH) ? {26'h0, input_change_flag,
                                              flags[14:10]} :
        (s_axi_araddr == `OFF_MASK_LOW)    ? {24'h000000, mask[7:1], 1'b0} :
        (s_axi_araddr == `OFF_MASK_HIGH)   ? {25'h0, mask[14:8]} :
        (s_axi_araddr == `OFF_CONTROL)     ? ctrl_word :
        (s_axi_araddr == `OFF_VECTOR)      ? {16'h0000, pc_vector} : 32'h0000_0000;
    wire           rd_known = known_offset(s_axi_araddr);

    // read channel
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // vectored_interrupt_controller
`default_nettype wire

// ---- testbench/vic_checker.sv ----
// assertion checker of the vectored interrupt controller
`timescale 1ns/1ns
`default_nettype none
module vic_checker (
    // clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // core side
    input wire logic        fetch_ready,
    input wire logic        global_enable_instr,
    input wire logic        global_disable_instr,
    input wire logic        return_and_enable_instr,
    input wire logic        pc_load,
    input wire logic [15:0] pc_vector,
    input wire logic        push_return,
    input wire logic        global_enable,
    input wire logic        irq_pending,
    // read channel
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_rresp
);
    logic live;
    always_ff @(posedge clk_sys)
        live <= rstn;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    property p_reset_vec;
        disable iff (1'b0) !rstn |=> pc_load && pc_vector == 16'h0000;
    endproperty
    property p_vec_set;
        live && pc_load |-> pc_vector inside {16'h0003, 16'h0006, 16'h0009, 16'h000F,
            16'h0012, 16'h0015, 16'h0018, 16'h001B, 16'h0021, 16'h0024, 16'h0027,
            16'h002A, 16'h0030, 16'h0033, 16'h0036};
    endproperty
    property p_push_pair;
        live && pc_load |-> push_return && !global_enable;
    endproperty
    property p_load_ready;
        live && pc_load |-> $past(fetch_ready);
    endproperty
    property p_load_pulse;
        live && pc_load |=> !pc_load;
    endproperty
    property p_vec_hold;
        live && !$stable(pc_vector) |-> pc_load;
    endproperty
    property p_disable;
        global_disable_instr |=> !global_enable;
    endproperty
    property p_enable;
        (global_enable_instr || return_and_enable_instr) && !global_enable && !irq_pending
            |=> global_enable;
    endproperty
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");
    a_vec_set: assert property (p_vec_set) else $error("vector not in table");
    a_push_pair: assert property (p_push_pair) else $error("take without push");
    a_load_ready: assert property (p_load_ready) else $error("load without ready");
    a_load_pulse: assert property (p_load_pulse) else $error("load too long");
    a_vec_hold: assert property (p_vec_hold) else $error("vector moved alone");
    a_disable: assert property (p_disable) else $error("disable ignored");
    a_enable: assert property (p_enable) else $error("enable ignored");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    c_wdt: cover property (pc_load && pc_vector == 16'h0003);
    c_low: cover property (pc_load && pc_vector == 16'h0036);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // vic_checker
bind vectored_interrupt_controller vic_checker u_vic_checker (.*);
`default_nettype wire

// ---- testbench/core_model.sv ----
// fetch sequencer of the core, prompt or slow
`timescale 1ns/1ns
`default_nettype none
module core_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // pacing
    input  wire logic stall,
    input  wire logic slow,
    // redirect accept
    output logic      fetch_ready
);
    logic [1:0] cnt;
    always_ff @(posedge clk_sys)
        cnt <= rstn ? cnt + 2'h1 : 2'h0;
    assign fetch_ready = !stall && (!slow || cnt == 2'h3);
endmodule // core_model
`default_nettype wire

// ---- testbench/vectored_interrupt_controller_tb.sv ----
// self-checking bench of the vectored interrupt controller
`timescale 1ns/1ns
`default_nettype none
`include "vic_regs.svh"
module vectored_interrupt_controller_tb
    import vic_pkg::*;
;
    logic        clk_sys = 1'b0, rstn = 1'b0, rdly = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sa;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, lfsr = 32'h84F7;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [14:0] src_event = 15'h0, ev;
    logic        input_change_event = 1'b0, global_enable_instr = 1'b0;
    logic        global_disable_instr = 1'b0, return_and_enable_instr = 1'b0;
    logic        stall = 1'b1, slow = 1'b0, fetch_ready;
    logic        pc_load, push_return, global_enable, irq_pending;
    logic [15:0] pc_vector;
    logic [34:0] e;
    int          n_mismatch = 0, n_checks = 0, cyc = 0;
    logic [15:0] exp_vec[$];
    logic [34:0] exp_rd[$];
    logic [1:0]  exp_wr[$];
    logic [15:0] vec[15] = '{16'h0003, 16'h0006, 16'h0009, 16'h000F, 16'h0012,
        16'h0015, 16'h0018, 16'h001B, 16'h0021, 16'h0024, 16'h0027, 16'h002A,
        16'h0030, 16'h0033, 16'h0036};
    vectored_interrupt_controller u_vectored_interrupt_controller (.*);
    core_model u_core_model (.*);
    always #10 clk_sys = ~clk_sys;
    function automatic logic [31:0] step(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [34:0] seen, input logic [34:0] want);
        n_checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_wr.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [34:0] x);
        exp_rd.push_back(x);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask
    // watcher of results and hang limit
    always @(posedge clk_sys) begin
        rdly <= rstn;
        cyc <= cyc + 1;
        if (rdly && pc_load)
            check(pc_vector, exp_vec.size() ? exp_vec.pop_front() : 16'hXXXX);
        if (s_axi_rvalid && s_axi_rready) begin
            e = exp_rd.pop_front();
            check({s_axi_rresp, e[34] ? s_axi_rdata : 32'h0}, e[33:0]);
        end
        if (s_axi_bvalid && s_axi_bready)
            check(s_axi_bresp, exp_wr.pop_front());
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        check({pc_load, pc_vector}, {1'b1, `VEC_RESET});
        rstn <= 1'b1;
        @(posedge clk_sys);
        // flags latch while masked and globally off
        lfsr = step(lfsr);
        ev = lfsr[14:0];
        src_event <= ev;
        input_change_event <= 1'b1;
        @(posedge clk_sys);
        src_event <= 15'h0;
        input_change_event <= 1'b0;
        @(posedge clk_sys);
        rd(`OFF_STATUS_LOW, {3'h4, 27'h0, ev[4:0]});
        rd(`OFF_STATUS_MID, {3'h4, 27'h0, ev[9:5]});
        rd(`OFF_STATUS_HIGH, {3'h4, 27'h0, ev[14:10]});
        check(irq_pending, 1'b0);
        wr(`OFF_STATUS_LOW, 32'h1F, `RESP_OKAY);
        wr(`OFF_STATUS_MID, 32'h1F, `RESP_OKAY);
        wr(`OFF_STATUS_HIGH, 32'h3F, `RESP_OKAY);
        rd(`OFF_STATUS_HIGH, {3'h4, 32'h0});
        rd(8'h1C, {1'b0, `RESP_SLVERR, 32'h0});
        wr(8'h1C, 32'h1, `RESP_SLVERR);
        // instructions drive the global enable
        global_enable_instr <= 1'b1;
        @(posedge clk_sys);
        global_enable_instr <= 1'b0;
        rd(`OFF_CONTROL, {3'h4, 32'h1});
        global_disable_instr <= 1'b1;
        @(posedge clk_sys);
        global_disable_instr <= 1'b0;
        rd(`OFF_CONTROL, {3'h4, 32'h0});
        wr(`OFF_MASK_LOW, 32'hFE, `RESP_OKAY);
        wr(`OFF_MASK_HIGH, 32'h7F, `RESP_OKAY);
        // input change flag sets once ext5 is enabled
        input_change_event <= 1'b1;
        @(posedge clk_sys);
        input_change_event <= 1'b0;
        rd(`OFF_STATUS_HIGH, {3'h4, 32'h20});
        rd(`OFF_CONTROL, {3'h4, 32'h8});
        rd(`OFF_MASK_LOW, {3'h4, 32'hFE});
        rd(`OFF_MASK_HIGH, {3'h4, 32'h7F});
        wr(`OFF_STATUS_HIGH, 32'h20, `RESP_OKAY);
        rd(`OFF_STATUS_HIGH, {3'h4, 32'h0});
        // pending requests served in rank order
        for (int r = 0; r < 3; r++) begin
            lfsr = step(lfsr);
            ev = lfsr[14:0] | 15'h4001;
            slow <= lfsr[20];
            wr(`OFF_CONTROL, r == 0 ? 32'h2 : 32'h3, `RESP_OKAY);
            src_event <= ev;
            @(posedge clk_sys);
            src_event <= 15'h0;
            repeat (3) @(posedge clk_sys);
            for (int i = 0; i < 15; i++) if (ev[i]) begin
                exp_vec.push_back(vec[i]);
                for (int k = 0; k < 50 && global_enable !== 1'b0; k++) @(posedge clk_sys);
                sa = i < 5 ? `OFF_STATUS_LOW : i < 10 ? `OFF_STATUS_MID : `OFF_STATUS_HIGH;
                wr(sa, 32'h1 << (i % 5), `RESP_OKAY);
                stall <= 1'b0;
                for (int k = 0; k < 50 && pc_load !== 1'b1; k++) @(posedge clk_sys);
                stall <= 1'b1;
                @(posedge clk_sys);
                return_and_enable_instr <= 1'b1;
                @(posedge clk_sys);
                return_and_enable_instr <= 1'b0;
                @(posedge clk_sys);
            end
        end
        repeat (10) @(posedge clk_sys);
        rd(`OFF_VECTOR, {3'h4, 16'h0, `VEC_EXT5});
        wr(`OFF_VECTOR, 32'h0, `RESP_OKAY);
        check(exp_vec.size(), 0);
        tally_and_finish();
    end
endmodule // vectored_interrupt_controller_tb
`default_nettype wire
